// ===== common/dtc_pkg.sv
// Shared constants and types for the dual timer/counter block
package dtc_pkg;
  // Register addresses on the 8-bit special function register port
  localparam logic [10:0] ADDR_TIMER_CONTROL = 11'h410;
  localparam logic [10:0] ADDR_TOGGLE_CTRL = 11'h411;
  localparam logic [10:0] ADDR_SYSTEM_CONFIG = 11'h440;
  localparam logic [10:0] ADDR_CNT_LO0 = 11'h450;
  localparam logic [10:0] ADDR_CNT_HI0 = 11'h451;
  localparam logic [10:0] ADDR_CNT_LO1 = 11'h452;
  localparam logic [10:0] ADDR_CNT_HI1 = 11'h453;
  localparam logic [10:0] ADDR_RELOAD_LO0 = 11'h454;
  localparam logic [10:0] ADDR_RELOAD_HI0 = 11'h455;
  localparam logic [10:0] ADDR_RELOAD_LO1 = 11'h456;
  localparam logic [10:0] ADDR_RELOAD_HI1 = 11'h457;
  localparam logic [10:0] ADDR_TIMER_MODE_CONTROL = 11'h45C;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Timer control field positions
  localparam int TCTL_FLAG1 = 7;
  localparam int TCTL_RUN1 = 6;
  localparam int TCTL_FLAG0 = 5;
  localparam int TCTL_RUN0 = 4;
  // Toggle control field positions
  localparam int TOG_EN0 = 0;
  localparam int TOG_EN1 = 2;
  // System config prescaler field
  localparam int SCFG_PSEL_LSB = 2;
  // Mode nibble layout, timer 0 in bits 3:0, timer 1 in bits 7:4
  localparam int MODE_NIB_W = 4;
  localparam int MODE_GATE = 3;
  localparam int MODE_CT = 2;
  // Mode field encodings
  localparam logic [1:0] MODE_AR16 = 2'h0;
  localparam logic [1:0] MODE_FREE16 = 2'h1;
  localparam logic [1:0] MODE_AR8 = 2'h2;
  localparam logic [1:0] MODE_SPLIT8 = 2'h3;
  // Prescaler selector encodings and terminal counts (divide minus one)
  localparam logic [1:0] PSEL_DIV4 = 2'h0;
  localparam logic [1:0] PSEL_DIV16 = 2'h1;
  localparam logic [1:0] PSEL_DIV64 = 2'h2;
  localparam logic [5:0] PLAST_DIV4 = 6'h03;
  localparam logic [5:0] PLAST_DIV16 = 6'h0F;
  localparam logic [5:0] PLAST_DIV64 = 6'h3F;
  // Register access request carried as one bundle
  typedef struct packed {
    logic [10:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dtc_sfr_req_t;
endpackage : dtc_pkg

// ===== design/dtc_timers.sv
// Dual 16-bit timer/counter with shared prescaler and four count modes
`timescale 1ns/100ps
module dtc_timers (
  input wire logic clk_sys_i, // 100 MHz oscillator clock
  input wire logic reset_n_i, // Asynchronous active-low reset
  input wire dtc_pkg::dtc_sfr_req_t sfr_req_i, // Register access request
  input wire logic [1:0] ext_event_i, // External count pins, timer 1 in bit 1
  input wire logic [1:0] ext_irq_pin_i, // Gate pins
  input wire logic [1:0] irq_ack_i, // Interrupt vectored, clears a flag
  output logic [7:0] sfr_rdata_o, // Registered read data
  output logic [1:0] overflow_flag_o, // Overflow flags
  output logic [1:0] toggle_out_o // Toggle outputs
);

  //////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0] system_config; // Prescaler select and spare bits
  logic [7:0] timer_mode_control; // Gate, source, mode per timer
  logic [7:0] timer_control; // Run bits and flags
  logic [7:0] toggle_ctrl; // Toggle output enables
  logic [7:0] count_low_byte [2]; // Count low bytes
  logic [7:0] count_high_byte [2]; // Count high bytes
  logic [7:0] reload_low_byte [2]; // Reload low holding registers
  logic [7:0] reload_high_byte [2]; // Reload high holding registers
  logic [5:0] presc_cnt; // Prescaler counter
  logic smp_en; // Pin sample phase
  logic smp_en_d; // Phase one cycle later
  logic [1:0] smp_new; // Latest pin sample
  logic [1:0] smp_old; // Previous pin sample
  logic [1:0] toggle_q; // Toggle output state

  //////////////////////////////////////////////////////////////////////////
  // Functions
  // Prescaler terminal count from selector
  function automatic logic [5:0] presc_last(input logic [1:0] sel);
    case (sel)
      dtc_pkg::PSEL_DIV16: presc_last = dtc_pkg::PLAST_DIV16;
      dtc_pkg::PSEL_DIV64: presc_last = dtc_pkg::PLAST_DIV64;
      default: presc_last = dtc_pkg::PLAST_DIV4; // Reserved code acts as divide by 4
    endcase
  endfunction : presc_last

  // One count step: returns {overflow, high, low}
  function automatic logic [16:0] count_step(input logic [1:0] mode, input logic [7:0] hi,
      input logic [7:0] lo, input logic [7:0] rhi, input logic [7:0] rlo);
    logic [16:0] sum16;
    logic [8:0] sum8;
    sum16 = {1'b0, hi, lo} + 17'h00001;
    sum8 = {1'b0, lo} + 9'h001;
    case (mode)
      dtc_pkg::MODE_AR16: count_step = sum16[16] ? {1'b1, rhi, rlo} : sum16;
      dtc_pkg::MODE_FREE16: count_step = sum16;
      dtc_pkg::MODE_AR8: count_step = sum8[8] ? {1'b1, hi, rlo} : {1'b0, hi, sum8[7:0]};
      default: count_step = {sum8[8], hi, sum8[7:0]}; // Split low byte wraps freely
    endcase
  endfunction : count_step

  //////////////////////////////////////////////////////////////////////////
  // Decoding
  wire wr = sfr_req_i.wr; // Write strobe
  wire [7:0] wd = sfr_req_i.wdata; // Write data
  wire [1:0] psel = system_config[dtc_pkg::SCFG_PSEL_LSB +: 2]; // Prescaler select
  wire [5:0] plast = presc_last(psel); // Prescaler terminal count
  wire prescaled_timer_clock_tick = (presc_cnt >= plast); // Prescaled timer clock pulse
  wire [5:0] next_presc = prescaled_timer_clock_tick ? 6'h00 : presc_cnt + 6'h01; // Prescaler next value
  wire [1:0] fall_evt = {2{smp_en_d}} & smp_old & ~smp_new; // Detected falling edges
  wire [1:0] run = {timer_control[dtc_pkg::TCTL_RUN1], timer_control[dtc_pkg::TCTL_RUN0]};
  wire [1:0] tog_en = {toggle_ctrl[dtc_pkg::TOG_EN1], toggle_ctrl[dtc_pkg::TOG_EN0]};
  wire [1:0] mode [2]; // Mode field per timer
  wire [1:0] cnt_en; // Count enable per timer
  wire [1:0] ovf; // Overflow per timer
  wire [1:0] wr_lo; // Low count byte write
  wire [1:0] wr_hi; // High count byte write
  wire [7:0] next_lo [2]; // Low count next value
  wire [7:0] next_hi [2]; // High count next value
  wire split0 = (mode[0] == dtc_pkg::MODE_SPLIT8); // Timer 0 in split mode
  wire [8:0] th0_sum = {1'b0, count_high_byte[0]} + 9'h001; // Split high byte step
  wire th0_en = split0 & run[1] & prescaled_timer_clock_tick; // Split high byte enable
  wire [1:0] flag_set; // Hardware flag set
  wire [1:0] flag_evt; // Overflow event feeding flag or toggle

  // Per-timer count paths
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tmr
      localparam int NB = gi * dtc_pkg::MODE_NIB_W; // Nibble base
      wire [3:0] nib = timer_mode_control[NB +: 4]; // This timer's nibble
      wire gate = nib[dtc_pkg::MODE_GATE]; // Gate bit
      wire src = nib[dtc_pkg::MODE_CT] ? fall_evt[gi] : prescaled_timer_clock_tick; // Count source
      wire run_ok = run[gi] & (~gate | ext_irq_pin_i[gi]); // Run and gate
      wire held = (gi == 1) && (nib[1:0] == dtc_pkg::MODE_SPLIT8); // Timer 1 holds
      wire [16:0] stp = count_step(nib[1:0], count_high_byte[gi], count_low_byte[gi],
          reload_high_byte[gi], reload_low_byte[gi]);
      wire [7:0] hi_cnt = (gi == 0 && split0) ? (th0_en ? th0_sum[7:0] : count_high_byte[gi])
          : (cnt_en[gi] ? stp[15:8] : count_high_byte[gi]);
      assign mode[gi] = nib[1:0];
      assign cnt_en[gi] = src & run_ok & ~held;
      assign ovf[gi] = cnt_en[gi] & stp[16];
      assign wr_lo[gi] = wr && sfr_req_i.addr == dtc_pkg::ADDR_CNT_LO0 + 11'(2 * gi);
      assign wr_hi[gi] = wr && sfr_req_i.addr == dtc_pkg::ADDR_CNT_HI0 + 11'(2 * gi);
      assign next_lo[gi] = wr_lo[gi] ? wd : (cnt_en[gi] ? stp[7:0] : count_low_byte[gi]);
      assign next_hi[gi] = wr_hi[gi] ? wd : hi_cnt;
      assign flag_set[gi] = flag_evt[gi] & ~tog_en[gi];
    end
  endgenerate

  // Split mode routes the high-byte carry onto timer 1's flag
  assign flag_evt[0] = ovf[0];
  assign flag_evt[1] = split0 ? (th0_en & th0_sum[8]) : ovf[1];

  // Timer control next value: set beats software or vector clear
  wire wr_tctl = wr && sfr_req_i.addr == dtc_pkg::ADDR_TIMER_CONTROL;
  wire [7:0] tctl_base = wr_tctl ? {wd[7:4], 4'h0} : timer_control;
  wire [1:0] flag_keep = {tctl_base[dtc_pkg::TCTL_FLAG1], tctl_base[dtc_pkg::TCTL_FLAG0]}
      & ~irq_ack_i;
  wire [1:0] next_flag = flag_keep | flag_set;
  wire [7:0] next_tctl = {next_flag[1], tctl_base[6], next_flag[0], tctl_base[4], 4'h0};

  // Read data selection
  function automatic logic [7:0] read_sel(input logic [10:0] a);
    case (a)
      dtc_pkg::ADDR_TIMER_CONTROL: read_sel = timer_control;
      dtc_pkg::ADDR_TOGGLE_CTRL: read_sel = toggle_ctrl;
      dtc_pkg::ADDR_SYSTEM_CONFIG: read_sel = system_config;
      dtc_pkg::ADDR_TIMER_MODE_CONTROL: read_sel = timer_mode_control;
      dtc_pkg::ADDR_CNT_LO0: read_sel = count_low_byte[0];
      dtc_pkg::ADDR_CNT_HI0: read_sel = count_high_byte[0];
      dtc_pkg::ADDR_CNT_LO1: read_sel = count_low_byte[1];
      dtc_pkg::ADDR_CNT_HI1: read_sel = count_high_byte[1];
      dtc_pkg::ADDR_RELOAD_LO0: read_sel = reload_low_byte[0];
      dtc_pkg::ADDR_RELOAD_HI0: read_sel = reload_high_byte[0];
      dtc_pkg::ADDR_RELOAD_LO1: read_sel = reload_low_byte[1];
      dtc_pkg::ADDR_RELOAD_HI1: read_sel = reload_high_byte[1];
      default: read_sel = dtc_pkg::RST_BYTE; // Unmapped reads as zero
    endcase
  endfunction : read_sel

  //////////////////////////////////////////////////////////////////////////
  // Prescaler and pin sampler
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      presc_cnt <= 6'h00;
      smp_en <= 1'b0;
      smp_en_d <= 1'b0;
      smp_new <= 2'h0;
      smp_old <= 2'h0;
    end else begin
      presc_cnt <= next_presc;
      smp_en <= ~smp_en; // Sample once per two cycles
      smp_en_d <= smp_en;
      if (smp_en) begin
        smp_new <= ext_event_i;
        smp_old <= smp_new;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      system_config <= dtc_pkg::RST_BYTE;
      timer_mode_control <= dtc_pkg::RST_BYTE;
      toggle_ctrl <= dtc_pkg::RST_BYTE;
      timer_control <= dtc_pkg::RST_BYTE;
    end else begin
      if (wr && sfr_req_i.addr == dtc_pkg::ADDR_SYSTEM_CONFIG) begin
        system_config <= wd;
      end
      if (wr && sfr_req_i.addr == dtc_pkg::ADDR_TIMER_MODE_CONTROL) begin
        timer_mode_control <= wd;
      end
      if (wr && sfr_req_i.addr == dtc_pkg::ADDR_TOGGLE_CTRL) begin
        toggle_ctrl <= {5'h00, wd[2], 1'b0, wd[0]};
      end
      timer_control <= next_tctl;
    end
  end

  // Count and reload bytes per timer
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cnt
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          count_low_byte[gi] <= dtc_pkg::RST_BYTE;
          count_high_byte[gi] <= dtc_pkg::RST_BYTE;
          reload_low_byte[gi] <= dtc_pkg::RST_BYTE;
          reload_high_byte[gi] <= dtc_pkg::RST_BYTE;
          toggle_q[gi] <= 1'b0;
        end else begin
          count_low_byte[gi] <= next_lo[gi];
          count_high_byte[gi] <= next_hi[gi];
          if (wr && sfr_req_i.addr == dtc_pkg::ADDR_RELOAD_LO0 + 11'(2 * gi)) begin
            reload_low_byte[gi] <= wd;
          end
          if (wr && sfr_req_i.addr == dtc_pkg::ADDR_RELOAD_HI0 + 11'(2 * gi)) begin
            reload_high_byte[gi] <= wd;
          end
          if (flag_evt[gi] && tog_en[gi]) begin
            toggle_q[gi] <= ~toggle_q[gi];
          end
        end
      end
    end
  endgenerate

  // Read port
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sfr_rdata_o <= dtc_pkg::RST_BYTE;
    end else if (sfr_req_i.rd) begin
      sfr_rdata_o <= read_sel(sfr_req_i.addr);
    end
  end

  assign overflow_flag_o = {timer_control[dtc_pkg::TCTL_FLAG1],
      timer_control[dtc_pkg::TCTL_FLAG0]};
  assign toggle_out_o = toggle_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  wire quiet0 = !wr_lo[0] && !wr_hi[0]; // No software write to timer 0 counts
  sequence s_div4_gap;
    (!prescaled_timer_clock_tick || psel != 2'h0) [*3] ##1 (prescaled_timer_clock_tick || psel != 2'h0);
  endsequence

  a_presc_div4: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    prescaled_timer_clock_tick && psel == 2'h0 |=> s_div4_gap) else $error("prescaler divide by 4 wrong");
  a_edge_spacing: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    fall_evt[0] |=> !fall_evt[0]) else $error("pin edges closer than two cycles");
  // Timer 1 as an ungated free 16-bit event counter must step once per edge
  a_event_count: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    fall_evt[1] && timer_mode_control[7:4] == 4'h5 && run[1] && !wr_lo[1]
    |=> count_low_byte[1] == 8'($past(count_low_byte[1]) + 8'h01))
    else $error("pin edge not counted");
  a_ar16_reload: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ovf[0] && mode[0] == 2'h0 && quiet0 |=>
    {count_high_byte[0], count_low_byte[0]} == $past({reload_high_byte[0],
    reload_low_byte[0]})) else $error("16-bit reload value wrong");
  a_flag_on_ovf: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ovf[0] && !tog_en[0] |=> overflow_flag_o[0]) else $error("overflow flag not set");
  a_ar8_high_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    mode[0] == 2'h2 && quiet0 |=> $stable(count_high_byte[0]))
    else $error("high byte moved in 8-bit reload");
  a_run_stop: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !run[0] && quiet0 |=> $stable(count_low_byte[0])) else $error("stopped timer counted");
  a_gate_block: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    timer_mode_control[dtc_pkg::MODE_GATE] && !ext_irq_pin_i[0] && quiet0
    |=> $stable(count_low_byte[0])) else $error("gated timer counted");
  a_free_wrap: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    cnt_en[0] && mode[0] == 2'h1 && quiet0 && {count_high_byte[0], count_low_byte[0]}
    == 16'hFFFF |=> {count_high_byte[0], count_low_byte[0]} == 16'h0000)
    else $error("free 16-bit count did not wrap");
  a_t1_split_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    mode[1] == 2'h3 && !wr_lo[1] |=> $stable(count_low_byte[1]))
    else $error("timer 1 counted in split mode");

endmodule : dtc_timers

// ===== sim/dtc_event_src.sv
// Model of the outside logic that drives the two event pins
`timescale 1ns/100ps
module dtc_event_src (
  input wire logic clk_sys_i, // Oscillator clock
  input wire logic reset_n_i, // Asynchronous active-low reset
  input wire logic [1:0] fire_i, // One request gives one low pulse
  output logic [1:0] ext_event_o // Event pins, idle high
);
  logic [2:0] phase [2]; // Pulse phase per pin, zero when idle
  ////////////////////////////////////////
  // Low for four clocks then high for three, so each level outlasts two clocks
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase[0] <= 3'h0;
      phase[1] <= 3'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (phase[b] != 3'h0) begin
          phase[b] <= phase[b] - 3'h1;
        end else if (fire_i[b]) begin
          phase[b] <= 3'h7;
        end
      end
    end
  end
  // Pin is low during the first half of a pulse
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      ext_event_o[b] = (phase[b] < 3'h4);
    end
  end
endmodule : dtc_event_src

// ===== sim/tb_dual_timer_counter_modes.sv
// Self-checking bench for the dual timer/counter
`timescale 1ns/100ps
module tb_dual_timer_counter_modes;
  logic clk_sys_i = 1'b0; // Oscillator clock
  logic reset_n_i = 1'b0; // Active-low reset
  dtc_pkg::dtc_sfr_req_t sfr_req_i = '0; // Register request
  logic [1:0] ext_event_i; // Event pins from the model
  logic [1:0] ext_irq_pin_i = 2'h3; // Gate pins
  logic [1:0] irq_ack_i = 2'h0; // Interrupt acknowledge
  logic [1:0] fire = 2'h0; // Pulse requests to the model
  logic [7:0] sfr_rdata_o;
  logic [1:0] overflow_flag_o;
  logic [1:0] toggle_out_o;
  logic [7:0] rd_val; // Last read value
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  ////////////////////////////////////////
  dtc_timers u_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sfr_req_i(sfr_req_i),
    .ext_event_i(ext_event_i), .ext_irq_pin_i(ext_irq_pin_i), .irq_ack_i(irq_ack_i),
    .sfr_rdata_o(sfr_rdata_o), .overflow_flag_o(overflow_flag_o), .toggle_out_o(toggle_out_o));
  dtc_event_src u_src (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .fire_i(fire),
    .ext_event_o(ext_event_i));
  // Clock and hang guard
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr_reg(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    sfr_req_i <= {a, 1'b1, 1'b0, d}; // Fields in order: addr, wr, rd, wdata
    @(posedge clk_sys_i);
    sfr_req_i <= '0;
  endtask : wr_reg
  // One-cycle read strobe, data registered at the taking edge
  task automatic rd_reg(input logic [10:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    sfr_req_i <= {a, 1'b0, 1'b1, 8'h00}; // Fields in order: addr, wr, rd, wdata
    @(posedge clk_sys_i);
    sfr_req_i <= '0;
    #1 d = sfr_rdata_o;
  endtask : rd_reg
  task automatic rd_chk(input string what, input logic [10:0] a, input logic [7:0] exp);
    rd_reg(a, rd_val);
    chk(what, exp, rd_val);
  endtask : rd_chk
  // Counts edges until the flag shows, bounded
  task automatic wait_flag(input int b, output int k);
    k = 0;
    do begin
      @(posedge clk_sys_i);
      #1 k++;
    end while (overflow_flag_o[b] !== 1'b1 && k < 3000);
    if (k >= 3000) chk("flag wait", 8'h01, 8'h00);
  endtask : wait_flag
  task automatic ack_flag(input int b);
    @(posedge clk_sys_i);
    irq_ack_i <= 2'(2'h1 << b);
    @(posedge clk_sys_i);
    irq_ack_i <= 2'h0;
  endtask : ack_flag
  // Second overflow interval; two edges go to the acknowledge
  task automatic measure(input int b, input logic [7:0] exp);
    wait_flag(b, n);
    ack_flag(b);
    wait_flag(b, n);
    ack_flag(b);
    chk("overflow period", exp, 8'(n + 2));
  endtask : measure
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rd_chk("system_config", dtc_pkg::ADDR_SYSTEM_CONFIG, 8'h00);
    rd_chk("timer_mode_control", dtc_pkg::ADDR_TIMER_MODE_CONTROL, 8'h00);
    rd_chk("timer_control", dtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
    wr_reg(11'h7FF, 8'hA5);
    rd_chk("unmapped", 11'h7FF, 8'h00);
    $display("test reset done");
    // Reload16 at every prescaler code
    wr_reg(dtc_pkg::ADDR_RELOAD_LO0, 8'hFE);
    wr_reg(dtc_pkg::ADDR_RELOAD_HI0, 8'hFF);
    wr_reg(dtc_pkg::ADDR_CNT_LO0, 8'hFE);
    wr_reg(dtc_pkg::ADDR_CNT_HI0, 8'hFF);
    wr_reg(dtc_pkg::ADDR_TIMER_CONTROL, 8'h10);
    for (int s = 0; s < 4; s++) begin
      wr_reg(dtc_pkg::ADDR_SYSTEM_CONFIG, 8'(s << 2));
      measure(0, (s == 3) ? 8'h08 : 8'(8'h08 << (2 * s)));
    end
    wr_reg(dtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
    wr_reg(dtc_pkg::ADDR_SYSTEM_CONFIG, 8'h00);
    rd_chk("reloaded high", dtc_pkg::ADDR_CNT_HI0, 8'hFF);
    $display("test reload16 done");
    // Reload8 keeps the high byte
    wr_reg(dtc_pkg::ADDR_TIMER_MODE_CONTROL, 8'h02);
    wr_reg(dtc_pkg::ADDR_CNT_HI0, 8'h5A);
    wr_reg(dtc_pkg::ADDR_RELOAD_LO0, 8'hFC);
    wr_reg(dtc_pkg::ADDR_CNT_LO0, 8'hFC);
    wr_reg(dtc_pkg::ADDR_TIMER_CONTROL, 8'h10);
    measure(0, 8'h10);
    wr_reg(dtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
    rd_chk("high kept", dtc_pkg::ADDR_CNT_HI0, 8'h5A);
    rd_reg(dtc_pkg::ADDR_CNT_LO0, rd_val);
    chk("low reload", 8'h01, {7'h0, rd_val >= 8'hFC});
    $display("test reload8 done");
    // Free16 wraps with no reload
    wr_reg(dtc_pkg::ADDR_TIMER_MODE_CONTROL, 8'h01);
    wr_reg(dtc_pkg::ADDR_RELOAD_HI0, 8'h12);
    wr_reg(dtc_pkg::ADDR_CNT_LO0, 8'hFF);
    wr_reg(dtc_pkg::ADDR_CNT_HI0, 8'hFF);
    wr_reg(dtc_pkg::ADDR_TIMER_CONTROL, 8'h10);
    wait_flag(0, n);
    wr_reg(dtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
    rd_chk("wrapped high", dtc_pkg::ADDR_CNT_HI0, 8'h00);
    $display("test free16 done");
    // Toggle enable replaces the flag
    wr_reg(dtc_pkg::ADDR_TOGGLE_CTRL, 8'h01);
    wr_reg(dtc_pkg::ADDR_CNT_LO0, 8'hFF);
    wr_reg(dtc_pkg::ADDR_CNT_HI0, 8'hFF);
    wr_reg(dtc_pkg::ADDR_TIMER_CONTROL, 8'h10);
    repeat (40) @(posedge clk_sys_i);
    rd_chk("flag held off", dtc_pkg::ADDR_TIMER_CONTROL, 8'h10);
    chk("toggle out", 8'h01, {7'h0, toggle_out_o[0]});
    wr_reg(dtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
    wr_reg(dtc_pkg::ADDR_TOGGLE_CTRL, 8'h00);
    $display("test toggle done");
    // Gate pin and run bit
    wr_reg(dtc_pkg::ADDR_TIMER_MODE_CONTROL, 8'h09);
    wr_reg(dtc_pkg::ADDR_CNT_LO0, 8'h00);
    wr_reg(dtc_pkg::ADDR_CNT_HI0, 8'h00);
    ext_irq_pin_i <= 2'h0;
    wr_reg(dtc_pkg::ADDR_TIMER_CONTROL, 8'h10);
    repeat (40) @(posedge clk_sys_i);
    rd_chk("gated count", dtc_pkg::ADDR_CNT_LO0, 8'h00);
    ext_irq_pin_i <= 2'h3;
    repeat (40) @(posedge clk_sys_i);
    wr_reg(dtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
    rd_reg(dtc_pkg::ADDR_CNT_LO0, rd_val);
    chk("pin high counts", 8'h01, {7'h0, rd_val != 8'h00});
    repeat (40) @(posedge clk_sys_i);
    rd_chk("stopped count", dtc_pkg::ADDR_CNT_LO0, rd_val);
    $display("test gate done");
    // Timer 1 counts pin events only
    wr_reg(dtc_pkg::ADDR_TIMER_MODE_CONTROL, 8'h50);
    wr_reg(dtc_pkg::ADDR_CNT_LO1, 8'h00);
    wr_reg(dtc_pkg::ADDR_CNT_HI1, 8'h00);
    wr_reg(dtc_pkg::ADDR_TIMER_CONTROL, 8'h40);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys_i);
      fire <= 2'h2;
      @(posedge clk_sys_i);
      fire <= 2'h0;
      repeat (10) @(posedge clk_sys_i);
    end
    rd_chk("event count", dtc_pkg::ADDR_CNT_LO1, 8'h03);
    wr_reg(dtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
    $display("test counter done");
    // Split mode, timer 1 held
    wr_reg(dtc_pkg::ADDR_TIMER_MODE_CONTROL, 8'h33);
    wr_reg(dtc_pkg::ADDR_CNT_LO1, 8'h77);
    wr_reg(dtc_pkg::ADDR_CNT_LO0, 8'h00);
    wr_reg(dtc_pkg::ADDR_CNT_HI0, 8'hFF);
    wr_reg(dtc_pkg::ADDR_TIMER_CONTROL, 8'h40);
    wait_flag(1, n);
    wr_reg(dtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
    rd_chk("held count", dtc_pkg::ADDR_CNT_LO1, 8'h77);
    rd_chk("low idle", dtc_pkg::ADDR_CNT_LO0, 8'h00);
    $display("test split done");
    tally_and_finish();
  end
endmodule : tb_dual_timer_counter_modes
